/* lud_decoder.sv */
`timescale 1ns/100ps
`include "lud_params.svh"

module lud_decoder (
   input  wire logic             clk,
   input  wire logic             rst_n,
   output logic [3:0]            progPage,
   output logic [11:0]           progAddr,
   output logic                  progFetch,
   input  wire lud_pkg::word_t   progRdata,
   output logic [3:0]            dataPage,
   output logic [11:0]           dataAddr,
   output logic                  dataRd,
   output logic                  dataWr,
   output logic                  pcHold,
   output logic [5:0]            regRdAddr,
   input  wire lud_pkg::word_t   regRdData,
   input  wire logic [1:0]       bankPin,
   output lud_pkg::opkind_t      opKind,
   output logic [5:0]            opCode,
   output logic [5:0]            regField,
   output logic                  accSel,
   output logic                  instrValid,
   output lud_pkg::word_t        regValue,
   output lud_pkg::word_t        acc1,
   output lud_pkg::word_t        acc2,
   output lud_pkg::regport_t     regPort,
   input  wire logic             accWrEn,
   input  wire lud_pkg::word_t   accWrData,
   input  wire logic             regWrEn,
   input  wire lud_pkg::word_t   regWrData,
   output logic                  extRegWr
);
   import lud_pkg::*;

   // ------------------------------------------------------------
   // Decode functions
   // ------------------------------------------------------------
   function automatic opkind_t kindOf(input logic [5:0] opc, input logic [5:0] fld);
      opkind_t k;
      k = K_OTHER;
      unique case (opc[5:1])
         `LUD_PAIR_LOAD_MEM:   k = K_LOAD_MEM;
         `LUD_PAIR_LOAD_REG:   k = K_LOAD_REG;
         `LUD_PAIR_STORE_MEM:  k = K_STORE_MEM;
         `LUD_PAIR_STORE_REG:  k = K_STORE_REG;
         `LUD_PAIR_SWAP_MEM:   k = K_SWAP_MEM;
         `LUD_PAIR_SWAP_REG:   k = K_SWAP_REG;
         `LUD_PAIR_SUM_MEM:    k = K_SUM_MEM;
         `LUD_PAIR_SUM_TO_MEM: k = K_SUM_TO_MEM;
         `LUD_PAIR_SUM_REG:    k = K_SUM_REG;
         `LUD_PAIR_DIFF_MEM:   k = K_DIFF_MEM;
         `LUD_PAIR_DIFF_TO:    k = K_DIFF_TO_MEM;
         `LUD_PAIR_DIFF_REG:   k = K_DIFF_REG;
         `LUD_PAIR_EXOR_MEM:   k = K_EXOR_MEM;
         `LUD_PAIR_EXOR_TO:    k = K_EXOR_TO_MEM;
         `LUD_PAIR_EXOR_REG:   k = K_EXOR_REG;
         `LUD_PAIR_CONJ_MEM:   k = K_CONJ_MEM;
         `LUD_PAIR_CONJ_TO:    k = K_CONJ_TO_MEM;
         `LUD_PAIR_CONJ_REG:   k = K_CONJ_REG;
         default: begin
            if (opc == `LUD_OPC_PAGE) begin
               k = (fld < `LUD_PAGE_SPLIT) ? K_DATA_PAGE : K_PROG_PAGE;
            end
         end
      endcase
      return k;
   endfunction

   function automatic regport_t portOf(input logic [5:0] a, input logic [1:0] bank);
      regport_t p;
      p = PORT_IO;
      if (a[5:4] > bank) begin
         p = PORT_NONE;
      end else begin
         unique case (a)
            `LUD_LOC_ZERO:  p = PORT_ZERO;
            `LUD_LOC_ACC1:  p = PORT_ACC1;
            `LUD_LOC_ACC2:  p = PORT_ACC2;
            `LUD_LOC_CT1:   p = PORT_CT1;
            `LUD_LOC_CT2:   p = PORT_CT2;
            `LUD_LOC_CONV1: p = PORT_CONV1;
            `LUD_LOC_CONV2: p = PORT_CONV2;
            default:        p = PORT_IO;
         endcase
      end
      return p;
   endfunction

   // ------------------------------------------------------------
   // State and decode wires
   // ------------------------------------------------------------
   state_t     state_q, state_d;
   logic [11:0] pc_q;
   logic [3:0]  progPage_q, dataPage_q;
   logic [5:0]  opCode_q, regField_q;
   opkind_t     kind_q;
   logic [11:0] effAddr_q;
   word_t       regValue_q, acc1_q, acc2_q;
   logic        valid_q, pendRd_q, pendWr_q;
   logic [1:0]  bankSync_q, bank_q;

   wire stF1 = (state_q == ST_FETCH1);
   wire stF2 = (state_q == ST_FETCH2);
   wire stDrd = (state_q == ST_DRD);
   wire stDwr = (state_q == ST_DWR);
   wire [5:0] fetchOpc = progRdata[`LUD_OPC_MSB:`LUD_OPC_LSB];
   wire [5:0] fetchFld = progRdata[`LUD_FLD_MSB:`LUD_FLD_LSB];
   wire opkind_t fetchKind = kindOf(fetchOpc, fetchFld);

   function automatic logic isMem(input opkind_t k);
      return k inside {K_LOAD_MEM, K_STORE_MEM, K_SWAP_MEM, K_SUM_MEM, K_SUM_TO_MEM,
                       K_DIFF_MEM, K_DIFF_TO_MEM, K_EXOR_MEM, K_EXOR_TO_MEM,
                       K_CONJ_MEM, K_CONJ_TO_MEM};
   endfunction

   function automatic logic isWr(input opkind_t k);
      return k inside {K_STORE_MEM, K_SWAP_MEM, K_SUM_TO_MEM, K_DIFF_TO_MEM,
                       K_EXOR_TO_MEM, K_CONJ_TO_MEM};
   endfunction

   wire fetchMem = isMem(fetchKind);
   wire writesMem = isWr(kind_q);
   wire readsMem = isMem(kind_q) && (kind_q != K_STORE_MEM);
   wire samePage = (progPage_q == dataPage_q);

   // Register read resolution
   wire [5:0] rdAddr = stF1 ? fetchFld : regField_q;
   wire regport_t rdPort = portOf(rdAddr, bank_q);
   wire regport_t fldPort = portOf(regField_q, bank_q);
   wire word_t rdResolved = (rdPort == PORT_ZERO || rdPort == PORT_NONE) ? `LUD_WORD_RST :
                            (rdPort == PORT_ACC1) ? acc1_q :
                            (rdPort == PORT_ACC2) ? acc2_q : regRdData;
   wire [11:0] effSum = 12'(progRdata + rdResolved);

   // Writes: accumulators stay local, zero and absent locations drop the write
   wire regToAcc1 = regWrEn && (fldPort == PORT_ACC1);
   wire regToAcc2 = regWrEn && (fldPort == PORT_ACC2);
   wire word_t acc1Next = (accWrEn && !accSel) ? accWrData : regToAcc1 ? regWrData : acc1_q;
   wire word_t acc2Next = (accWrEn && accSel) ? accWrData : regToAcc2 ? regWrData : acc2_q;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_FETCH1: state_d = fetchMem ? ST_FETCH2 : ST_FETCH1;
         ST_FETCH2: state_d = samePage ? ST_DRD : ST_FETCH1;
         ST_DRD:    state_d = writesMem ? ST_DWR : ST_FETCH1;
         ST_DWR:    state_d = ST_FETCH1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_FETCH1;
         pc_q    <= `LUD_PC_RST;
      end else begin
         state_q <= state_d;
         if (stF1 || stF2) begin
            pc_q <= pc_q + 12'h001;
         end
      end
   end

   // Page registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         progPage_q <= `LUD_PAGE_RST;
         dataPage_q <= `LUD_PAGE_RST;
      end else if (stF1 && fetchKind == K_DATA_PAGE) begin
         dataPage_q <= fetchFld[3:0];
      end else if (stF1 && fetchKind == K_PROG_PAGE) begin
         progPage_q <= fetchFld[3:0];
      end
   end

   // Instruction fields
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opCode_q   <= 6'h00;
         regField_q <= 6'h00;
         kind_q     <= K_OTHER;
         effAddr_q  <= `LUD_WORD_RST;
         regValue_q <= `LUD_WORD_RST;
         valid_q    <= 1'b0;
      end else begin
         valid_q <= (stF1 && !fetchMem) || stF2;
         if (stF1) begin
            opCode_q   <= fetchOpc;
            regField_q <= fetchFld;
            kind_q     <= fetchKind;
            regValue_q <= rdResolved;
         end
         if (stF2) begin
            effAddr_q  <= effSum;
            regValue_q <= rdResolved;
         end
      end
   end

   // Overlapped data access when the data module is a separate one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pendRd_q <= 1'b0;
         pendWr_q <= 1'b0;
      end else begin
         pendRd_q <= stF2 && !samePage && readsMem;
         pendWr_q <= stF2 && !samePage && writesMem;
      end
   end

   // Accumulators and bank strap synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc1_q     <= `LUD_WORD_RST;
         acc2_q     <= `LUD_WORD_RST;
         bankSync_q <= 2'h0;
         bank_q     <= 2'h0;
      end else begin
         acc1_q     <= acc1Next;
         acc2_q     <= acc2Next;
         bankSync_q <= bankPin;
         bank_q     <= bankSync_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign progPage   = progPage_q;
   assign progAddr   = pc_q;
   assign progFetch  = stF1 || stF2;
   assign dataPage   = dataPage_q;
   assign dataAddr   = effAddr_q;
   assign dataRd     = (stDrd && readsMem) || pendRd_q;
   assign dataWr     = stDwr || pendWr_q;
   assign pcHold     = stDrd || stDwr;
   assign regRdAddr  = rdAddr;
   assign opKind     = kind_q;
   assign opCode     = opCode_q;
   assign regField   = regField_q;
   assign accSel     = opCode_q[0];
   assign instrValid = valid_q;
   assign regValue   = regValue_q;
   assign acc1       = acc1_q;
   assign acc2       = acc2_q;
   assign regPort    = fldPort;
   assign extRegWr   = regWrEn && !(fldPort inside {PORT_ZERO, PORT_NONE, PORT_ACC1, PORT_ACC2});

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_read3;
      (stDrd && pcHold) ##1 (stF1 && $stable(progAddr));
   endsequence
   sequence s_write4;
      stDrd ##1 (stDwr && dataWr) ##1 stF1;
   endsequence

   property p_two_word;
      (stF1 && fetchMem) |=> stF2 ##1 instrValid;
   endproperty
   a_two_word: assert property (p_two_word) else $error("second word not fetched");

   property p_split;
      stF1 |=> (opCode == $past(progRdata[11:6])) && (regField == $past(progRdata[5:0]));
   endproperty
   a_split: assert property (p_split) else $error("field split wrong");

   property p_acc_sel;
      accWrEn && opCode[0] && !regWrEn |=> acc2 == $past(accWrData) && $stable(acc1);
   endproperty
   a_acc_sel: assert property (p_acc_sel) else $error("wrong accumulator chosen");

   property p_zero;
      (stF1 && !fetchMem && fetchFld == 6'h00) |=> regValue == 12'sh000;
   endproperty
   a_zero: assert property (p_zero) else $error("location zero not zero");

   property p_ports;
      instrValid && regField == 6'h03 |-> regPort == PORT_CT1;
   endproperty
   a_ports: assert property (p_ports) else $error("location three misrouted");

   property p_acc_local;
      regWrEn && regField == 6'h01 && !accWrEn |-> !extRegWr ##1 acc1 == $past(regWrData);
   endproperty
   a_acc_local: assert property (p_acc_local) else $error("accumulator write left unit");

   property p_sep;
      (stF2 && !samePage && readsMem) |=> stF1 && dataRd && !pcHold;
   endproperty
   a_sep: assert property (p_sep) else $error("separate page access not overlapped");

   property p_same_read;
      (stF2 && samePage && !writesMem) |=> s_read3;
   endproperty
   a_same_read: assert property (p_same_read) else $error("same page read not three cycles");

   property p_same_write;
      (stF2 && samePage && writesMem) |=> s_write4;
   endproperty
   a_same_write: assert property (p_same_write) else $error("same page write not four cycles");

   property p_page;
      (stF1 && fetchOpc == 6'h10 && fetchFld < 6'h20) |=> dataPage == $past(fetchFld[3:0]) && $stable(progPage);
   endproperty
   a_page: assert property (p_page) else $error("data page not selected");
endmodule

/* lud_params.svh */
`ifndef LUD_PARAMS_SVH
`define LUD_PARAMS_SVH

// Word layout
`define LUD_WORD_W     12
`define LUD_OPC_MSB    11
`define LUD_OPC_LSB    6
`define LUD_FLD_MSB    5
`define LUD_FLD_LSB    0

// Operation pairs: operation code bits 5..1, bit 0 picks the accumulator
`define LUD_PAIR_LOAD_MEM   5'h1f
`define LUD_PAIR_LOAD_REG   5'h1e
`define LUD_PAIR_STORE_MEM  5'h15
`define LUD_PAIR_STORE_REG  5'h14
`define LUD_PAIR_SWAP_MEM   5'h1d
`define LUD_PAIR_SWAP_REG   5'h1c
`define LUD_PAIR_SUM_MEM    5'h13
`define LUD_PAIR_SUM_TO_MEM 5'h11
`define LUD_PAIR_SUM_REG    5'h12
`define LUD_PAIR_DIFF_MEM   5'h0f
`define LUD_PAIR_DIFF_TO    5'h0d
`define LUD_PAIR_DIFF_REG   5'h0e
`define LUD_PAIR_EXOR_MEM   5'h03
`define LUD_PAIR_EXOR_TO    5'h01
`define LUD_PAIR_EXOR_REG   5'h02
`define LUD_PAIR_CONJ_MEM   5'h1b
`define LUD_PAIR_CONJ_TO    5'h19
`define LUD_PAIR_CONJ_REG   5'h1a
`define LUD_OPC_PAGE        6'h10
`define LUD_PAGE_SPLIT      6'h20

// Register locations
`define LUD_LOC_ZERO   6'h00
`define LUD_LOC_ACC1   6'h01
`define LUD_LOC_ACC2   6'h02
`define LUD_LOC_CT1    6'h03
`define LUD_LOC_CT2    6'h04
`define LUD_LOC_CONV1  6'h05
`define LUD_LOC_CONV2  6'h06

// Reset values
`define LUD_PC_RST     12'h000
`define LUD_PAGE_RST   4'h0
`define LUD_WORD_RST   12'h000

`endif

/* lud_pkg.sv */
package lud_pkg;
   typedef logic signed [11:0] word_t;
   typedef enum logic [1:0] {ST_FETCH1, ST_FETCH2, ST_DRD, ST_DWR} state_t;
   typedef enum logic [4:0] {
      K_LOAD_MEM, K_LOAD_REG, K_STORE_MEM, K_STORE_REG, K_SWAP_MEM, K_SWAP_REG,
      K_SUM_MEM, K_SUM_TO_MEM, K_SUM_REG, K_DIFF_MEM, K_DIFF_TO_MEM, K_DIFF_REG,
      K_EXOR_MEM, K_EXOR_TO_MEM, K_EXOR_REG, K_CONJ_MEM, K_CONJ_TO_MEM, K_CONJ_REG,
      K_DATA_PAGE, K_PROG_PAGE, K_OTHER
   } opkind_t;
   typedef enum logic [3:0] {
      PORT_ZERO, PORT_ACC1, PORT_ACC2, PORT_CT1, PORT_CT2,
      PORT_CONV1, PORT_CONV2, PORT_IO, PORT_NONE
   } regport_t;
endpackage

/* lud_prog_mem_model.sv */
`timescale 1ns/100ps
module lud_prog_mem_model (
   input  wire logic             clk,
   input  wire logic [3:0]       progPage,
   input  wire logic [11:0]      progAddr,
   input  wire logic             progFetch,
   output lud_pkg::word_t        progRdata,
   input  wire logic [5:0]       regRdAddr,
   output lud_pkg::word_t        regRdData
);
   import lud_pkg::*;
   word_t      progMem [0:4095];
   word_t      lastWord = '0;
   logic [11:0] memIdx;

   // ---------------------------------------------
   // Program modules, one per page
   // ---------------------------------------------
   assign memIdx = {progPage, progAddr[7:0]};
   // Outside fetch cycles the port shows no stale word
   assign progRdata = progFetch ? progMem[memIdx] : ~lastWord;
   always @(posedge clk) begin
      if (progFetch) begin
         lastWord <= progMem[memIdx];
      end
   end

   // ---------------------------------------------
   // Register units answer every location, also 0 to 2 and absent ones
   // ---------------------------------------------
   assign regRdData = word_t'({6'h14, regRdAddr});
endmodule

/* lud_testbench.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin badCount++; $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
   import lud_pkg::*;
   typedef struct {logic [5:0] opc; opkind_t kind; logic rd; logic wr;} lud_row_t;
   typedef struct {logic [11:0] w1; opkind_t kind; logic mem; logic rd; logic wr; logic same; logic [11:0] addr;} lud_exp_t;

   logic        clk = 1'b0;
   logic        rst_n, progFetch, dataRd, dataWr, pcHold, accSel, instrValid, accWrEn, regWrEn, extRegWr, bb, present;
   logic [1:0]  bankPin;
   logic [3:0]  progPage, dataPage;
   logic [5:0]  regRdAddr, opCode, regField;
   logic [11:0] progAddr, dataAddr, w1;
   word_t       progRdata, regRdData, regValue, acc1, acc2, accWrData, regWrData;
   opkind_t     opKind;
   regport_t    regPort;
   regport_t    portExp [5] = '{PORT_CT1, PORT_CT2, PORT_CONV1, PORT_CONV2, PORT_IO};
   lud_exp_t    q [$];
   lud_exp_t    e;
   int          badCount, totalChecks, cycles, n, k, addr;
   lud_row_t    rows [18] = '{
      '{6'h3e, K_LOAD_MEM, 1'b1, 1'b0}, '{6'h3c, K_LOAD_REG, 1'b0, 1'b0}, '{6'h2a, K_STORE_MEM, 1'b0, 1'b1},
      '{6'h28, K_STORE_REG, 1'b0, 1'b0}, '{6'h3a, K_SWAP_MEM, 1'b1, 1'b1}, '{6'h38, K_SWAP_REG, 1'b0, 1'b0},
      '{6'h26, K_SUM_MEM, 1'b1, 1'b0}, '{6'h22, K_SUM_TO_MEM, 1'b1, 1'b1}, '{6'h24, K_SUM_REG, 1'b0, 1'b0},
      '{6'h1e, K_DIFF_MEM, 1'b1, 1'b0}, '{6'h1a, K_DIFF_TO_MEM, 1'b1, 1'b1}, '{6'h1c, K_DIFF_REG, 1'b0, 1'b0},
      '{6'h06, K_EXOR_MEM, 1'b1, 1'b0}, '{6'h02, K_EXOR_TO_MEM, 1'b1, 1'b1}, '{6'h04, K_EXOR_REG, 1'b0, 1'b0},
      '{6'h36, K_CONJ_MEM, 1'b1, 1'b0}, '{6'h32, K_CONJ_TO_MEM, 1'b1, 1'b1}, '{6'h34, K_CONJ_REG, 1'b0, 1'b0}};

   lud_decoder uut (.clk(clk), .rst_n(rst_n), .progPage(progPage), .progAddr(progAddr), .progFetch(progFetch),
      .progRdata(progRdata), .dataPage(dataPage), .dataAddr(dataAddr), .dataRd(dataRd), .dataWr(dataWr),
      .pcHold(pcHold), .regRdAddr(regRdAddr), .regRdData(regRdData), .bankPin(bankPin), .opKind(opKind),
      .opCode(opCode), .regField(regField), .accSel(accSel), .instrValid(instrValid), .regValue(regValue),
      .acc1(acc1), .acc2(acc2), .regPort(regPort), .accWrEn(accWrEn), .accWrData(accWrData),
      .regWrEn(regWrEn), .regWrData(regWrData), .extRegWr(extRegWr));

   lud_prog_mem_model pm (.clk(clk), .progPage(progPage), .progAddr(progAddr), .progFetch(progFetch),
      .progRdata(progRdata), .regRdAddr(regRdAddr), .regRdData(regRdData));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         badCount++;
         print_verdict;
      end
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Same instruction at every place, then let the pipe settle
   task automatic fill(input logic [11:0] w);
      for (int j = 0; j < 4096; j++) pm.progMem[j] = w;
      repeat (6) @(negedge clk);
   endtask

   task automatic wrReg(input logic [11:0] v, input logic ext);
      regWrEn = 1'b1;
      regWrData = v;
      #1 `CHK(extRegWr, ext)
      @(negedge clk);
      regWrEn = 1'b0;
   endtask

   task automatic chkReset;
      `CHK(progAddr, 12'h000)
      `CHK({progPage, dataPage}, 8'h00)
      `CHK({acc1, acc2}, 24'h000000)
      `CHK({dataRd, dataWr, instrValid, progFetch}, 4'h1)
   endtask

   // Extra cycles spent by the previous instruction beyond its fetches
   function automatic int extra(lud_exp_t x);
      return (x.mem && x.same) ? (x.wr ? 2 : 1) : 0;
   endfunction

   // ---------------------------------------------
   // Main sequence: table run in same-page then split-page mode
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      bankPin = 2'h0;
      accWrEn = 1'b0;
      regWrEn = 1'b0;
      accWrData = 12'h000;
      regWrData = 12'h000;
      for (int j = 0; j < 4096; j++) pm.progMem[j] = 12'h000;
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            pm.progMem[addr] = 12'h401;
            addr++;
            q.push_back('{12'h401, K_DATA_PAGE, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000});
         end
         for (int i = 0; i < 36; i++) begin
            bb = i[0];
            w1 = {rows[i / 2].opc[5:1], bb, bb ? 6'h07 : 6'h00};
            e = '{w1, rows[i / 2].kind, rows[i / 2].rd | rows[i / 2].wr, rows[i / 2].rd, rows[i / 2].wr,
                  p == 0, 12'h100 + 12'(i) + (bb ? 12'h507 : 12'h000)};
            q.push_back(e);
            pm.progMem[addr] = w1;
            addr++;
            if (e.mem) begin
               pm.progMem[addr] = 12'h100 + 12'(i);
               addr++;
            end
         end
      end
      q.push_back('{12'h000, K_OTHER, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000});
      repeat (4) @(negedge clk);
      chkReset;
      rst_n = 1'b1;
      for (k = 0; k < q.size(); k++) begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (instrValid !== 1'b1 && n < 20);
         e = q[k];
         if (k > 0) `CHK(n, extra(q[k - 1]) + (e.mem ? 2 : 1))
         `CHK({opCode, regField}, e.w1)
         `CHK(accSel, e.w1[6])
         `CHK(opKind, e.kind)
         if (e.mem) begin
            `CHK(dataAddr, e.addr)
            `CHK({pcHold, dataRd, dataWr, progFetch}, {e.same, e.rd, e.wr & !e.same, !e.same})
            `CHK(dataPage, {3'h0, !e.same})
         end
      end

      // ---------------------------------------------
      // Register space, banks and page registers
      // ---------------------------------------------
      fill(12'hf01);
      `CHK(regPort, PORT_ACC1)
      wrReg(12'h7ff, 1'b0);
      `CHK(acc1, 12'h7ff)
      fill(12'hf40);
      accWrEn = 1'b1;
      accWrData = 12'h123;
      @(negedge clk);
      accWrEn = 1'b0;
      `CHK({acc1, acc2}, 24'h7ff123)
      fill(12'hf00);
      `CHK(regPort, PORT_ZERO)
      `CHK(regValue, 12'h000)
      wrReg(12'h555, 1'b0);
      `CHK({acc1, acc2}, 24'h7ff123)
      fill(12'hf02);
      `CHK(regValue, 12'h123)
      for (k = 3; k < 8; k++) begin
         fill({6'h3c, 6'(k)});
         `CHK(regPort, portExp[k - 3])
         `CHK(regRdAddr, 6'(k))
         `CHK(regValue, 12'h500 + 12'(k))
         wrReg(12'h0aa, 1'b1);
      end
      for (k = 0; k < 4; k++) begin
         present = k[0];
         bankPin = 2'(k);
         w1 = {6'h3c, (k < 2) ? 6'h10 : 6'h3f};
         fill(w1);
         `CHK(regPort, present ? PORT_IO : PORT_NONE)
         `CHK(regValue, present ? {6'h14, w1[5:0]} : 12'h000)
         wrReg(12'h0cc, present);
      end
      fill(12'h41f);
      `CHK({progPage, dataPage}, 8'h0f)
      fill(12'h42a);
      `CHK({progPage, dataPage}, 8'haf)
      `CHK(opKind, K_PROG_PAGE)
      fill(12'h420);
      `CHK({progPage, dataPage}, 8'h0f)
      rst_n = 1'b0;
      #1 chkReset;
      @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHK({progAddr, instrValid}, 13'h0003)
      print_verdict;
   end
endmodule
